/* rtl/slf_defines.vh */
// Shared constants of the serial loader link front end.
// Assumes a single 20 MHz system clock taken straight from the crystal.
`ifndef SLF_DEFINES_VH
`define SLF_DEFINES_VH
// ----------------------------------------------------------------------
// Clock and character format.
// ----------------------------------------------------------------------
`define SLF_CLK_HZ 20000000
`define SLF_DATA_BITS 4'h8
`define SLF_STOP_INDEX 4'h9
// ----------------------------------------------------------------------
// Byte values on the link.
// ----------------------------------------------------------------------
`define SLF_SYNC_BYTE 8'h55
`define SLF_ACK_BYTE 8'hCC
`define SLF_NAK_BYTE 8'h33
`define SLF_IDLE_BYTE 8'h00
// ----------------------------------------------------------------------
// Baud detection.
// ----------------------------------------------------------------------
`define SLF_DIV_W 20
`define SLF_SPAN_FALLS 4'h7
`define SLF_SPAN_SHIFT 4
`define SLF_MIN_DIV 20'h00010
`define SLF_MAX_SPAN 20'hFFFFF
// ----------------------------------------------------------------------
// Transmit buffer.
// ----------------------------------------------------------------------
`define SLF_FIFO_WIDTH 8
`define SLF_FIFO_DEPTH 8
`define SLF_FIFO_AW 3
`endif

/* rtl/slf_fifo.v */
// Small synchronous FIFO with valid and ready on both sides.
// Assumes one clock; DEPTH is a power of two equal to 2**AW.
`timescale 1ns/1ps
`default_nettype none
module slf_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire i_clock, // System clock.
  input wire i_rst_b, // Asynchronous reset, active low.
  input wire i_in_valid, // Writer offers a word.
  output reg o_in_ready, // Room for a word.
  input wire [WIDTH-1:0] i_in_data, // Word written.
  output reg o_out_valid, // A word is waiting.
  input wire i_out_ready, // Reader takes the word.
  output wire [WIDTH-1:0] o_out_data // Oldest word.
);
  localparam [AW:0] FULL = DEPTH;
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  reg [AW:0] next_count;
  wire push = i_in_valid && o_in_ready;
  wire pop = o_out_valid && i_out_ready;

  assign o_out_data = mem[rd_ptr];

  // Next fill level from this cycle's push and pop.
  always @* begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  // Storage has no reset; only written words are read.
  always @(posedge i_clock) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  // Pointers and registered full and empty flags.
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      o_in_ready <= 1'b1;
      o_out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= next_count;
      o_in_ready <= (next_count != FULL);
      o_out_valid <= (next_count != {(AW+1){1'b0}});
    end
  end
endmodule
`default_nettype wire

/* rtl/slf_uart_tx.v */
// Asynchronous transmitter: one start bit, eight data bits, one stop bit.
// Assumes i_div is at least sixteen and steady while busy.
`timescale 1ns/1ps
`default_nettype none
`include "slf_defines.vh"
module slf_uart_tx (
  input wire i_clock, // System clock.
  input wire i_rst_b, // Asynchronous reset, active low.
  input wire [`SLF_DIV_W-1:0] i_div, // Clocks per bit.
  input wire i_start, // Start a character when idle.
  input wire [7:0] i_data, // Character to send.
  output reg o_busy, // Character in progress.
  output reg o_line // Serial line, idles high.
);
  reg [9:0] shift;
  reg [3:0] bits;
  reg [`SLF_DIV_W-1:0] cnt;

  // Frame shifter; the stop bit is held a full bit time before idling.
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      shift <= 10'h3FF;
      bits <= 4'h0;
      cnt <= {`SLF_DIV_W{1'b0}};
      o_busy <= 1'b0;
      o_line <= 1'b1;
    end else if (!o_busy) begin
      o_line <= 1'b1;
      if (i_start) begin
        shift <= {1'b1, i_data, 1'b0};
        bits <= 4'hA;
        cnt <= {`SLF_DIV_W{1'b0}};
        o_busy <= 1'b1;
      end
    end else if (cnt != {`SLF_DIV_W{1'b0}}) begin
      cnt <= cnt - 1'b1;
    end else if (bits == 4'h0) begin
      o_busy <= 1'b0;
      o_line <= 1'b1;
    end else begin
      o_line <= shift[0];
      shift <= {1'b1, shift[9:1]};
      cnt <= i_div - 1'b1;
      bits <= bits - 1'b1;
    end
  end
endmodule
`default_nettype wire

/* rtl/slf_front.v */
// Link front end of a boot-time serial loader: async port with baud
// detection and a host-clocked synchronous slave port, one byte stream.
// Assumes loader logic on the user ports; link pins are asynchronous.
//
// How it works
// - Both ports carry the same byte stream to and from the loader.
// - First port that locks is used alone until reset or handover.
// - Async characters are eight data bits, no parity, one stop bit.
// - Async bit time is at least sixteen clocks.
// - Falling edges of the pattern are timed to derive the baud divisor.
// - After detection one 0xCC byte goes out at the detected rate.
// - Sync link uses polarity one, phase one, most significant bit first.
// - On the sync link the block is a slave and never makes the clock.
// - Loader runs from the crystal with the PLL kept off.
// - Packets are answered with 0xCC when good or 0x33 when faulty.
// - The first non-zero byte is the host's answer.
`timescale 1ns/1ps
`default_nettype none
`include "slf_defines.vh"
module slf_front (
  input wire i_clock, // System clock, 20 MHz.
  input wire i_rst_b, // Asynchronous reset, active low.
  input wire i_async_rx, // Async receive pin.
  output wire o_async_tx, // Async transmit pin.
  input wire i_sync_clk, // Sync clock pin from the host.
  input wire i_sync_sel_b, // Sync slave select, active low.
  input wire i_sync_mosi, // Sync data from the host.
  output reg o_sync_miso, // Sync data to the host.
  output reg o_sync_miso_oe, // Drive enable for the data-out pin.
  output reg [7:0] o_rx_data, // Received byte.
  output reg o_rx_valid, // Pulse: o_rx_data is new.
  input wire [7:0] i_tx_data, // Byte to send.
  input wire i_tx_valid, // Byte offered.
  output wire o_tx_ready, // Transmit buffer has room.
  input wire i_send_ack, // Pulse: queue one acknowledge byte.
  input wire i_send_nak, // Pulse: queue one negative acknowledge byte.
  input wire i_resp_arm, // Pulse: wait for the host's answer byte.
  output reg o_resp_valid, // Pulse: host answer seen.
  output reg o_resp_ack, // Last answer was an acknowledge.
  output reg o_resp_nak, // Last answer was a negative acknowledge.
  input wire i_handover, // Pulse: new code takes over, listen again.
  output wire o_async_sel, // Async port locked.
  output wire o_sync_sel, // Sync port locked.
  output reg [`SLF_DIV_W-1:0] o_baud_div, // Detected clocks per bit.
  output reg o_pll_enable // PLL enable, held off.
);
  // --------------------------------------------------------------------
  // States.
  // --------------------------------------------------------------------
  localparam [2:0] PS_LISTEN = 3'h1;
  localparam [2:0] PS_ASYNC = 3'h2;
  localparam [2:0] PS_SYNC = 3'h4;
  localparam [3:0] AB_IDLE = 4'h1;
  localparam [3:0] AB_MEAS = 4'h2;
  localparam [3:0] AB_SETTLE = 4'h4;
  localparam [3:0] AB_RUN = 4'h8;

  reg [2:0] port_state;
  reg [3:0] ab_state;
  reg [`SLF_DIV_W-1:0] span;
  reg [3:0] falls;
  reg rx_busy;
  reg [`SLF_DIV_W-1:0] rx_cnt;
  reg [3:0] rx_bits;
  reg [7:0] rx_shift;
  reg async_stb;
  reg [7:0] async_data;
  reg [2:0] spi_bits;
  reg [7:0] spi_in;
  reg [7:0] spi_out;
  reg sync_stb;
  reg [7:0] sync_data;
  reg ack_pend;
  reg nak_pend;
  reg resp_armed;
  wire tx_busy;
  wire fifo_valid;
  wire [7:0] fifo_data;

  // --------------------------------------------------------------------
  // Pin synchronisers.
  // --------------------------------------------------------------------
  wire [3:0] pin_raw = {i_sync_mosi, i_sync_sel_b, i_sync_clk, i_async_rx};
  wire [3:0] pin_s;
  wire [3:0] pin_p;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_sync
      reg meta;
      reg stage;
      reg prev;
      // Two flops per pin, a third for edge finding; all idle high.
      always @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
          meta <= 1'b1;
          stage <= 1'b1;
          prev <= 1'b1;
        end else begin
          meta <= pin_raw[g];
          stage <= meta;
          prev <= stage;
        end
      end
      assign pin_s[g] = stage;
      assign pin_p[g] = prev;
    end
  endgenerate

  wire rx = pin_s[0];
  wire rx_fall = pin_p[0] && !pin_s[0];
  wire sclk_rise = !pin_p[1] && pin_s[1];
  wire sclk_fall = pin_p[1] && !pin_s[1];
  wire sel_b = pin_s[2];
  wire mosi = pin_s[3];

  // --------------------------------------------------------------------
  // Port selection and transmit source.
  // --------------------------------------------------------------------
  wire async_ok = (port_state != PS_SYNC);
  wire sync_ok = (port_state != PS_ASYNC);
  wire spi_on = sync_ok && !sel_b;
  wire spi_load = spi_on && sclk_fall && (spi_bits == 3'h0);
  wire have_byte = ack_pend || nak_pend || fifo_valid;
  wire tx_go = (ab_state == AB_RUN) && !tx_busy && have_byte;
  wire take = tx_go || spi_load;
  wire fifo_pop = take && !ack_pend && !nak_pend;
  wire spi_last = spi_on && sclk_rise && (spi_bits == 3'h7);
  wire [7:0] tx_byte = ack_pend ? `SLF_ACK_BYTE :
                       nak_pend ? `SLF_NAK_BYTE :
                       fifo_valid ? fifo_data : `SLF_IDLE_BYTE;
  wire ab_done = (ab_state == AB_SETTLE) &&
                 (span == (o_baud_div + {1'b0, o_baud_div[`SLF_DIV_W-1:1]}));
  wire byte_stb = async_stb || sync_stb;
  wire [7:0] byte_val = async_stb ? async_data : sync_data;

  assign o_async_sel = port_state[1];
  assign o_sync_sel = port_state[2];

  // Port lock: async on a detected pattern, sync on a whole frame.
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      port_state <= PS_LISTEN;
    end else begin
      case (port_state)
        PS_LISTEN: begin
          if (ab_state == AB_MEAS && rx_fall && falls == `SLF_SPAN_FALLS &&
              (span >> `SLF_SPAN_SHIFT) >= `SLF_MIN_DIV) begin
            port_state <= PS_ASYNC;
          end else if (spi_last) begin
            port_state <= PS_SYNC;
          end
        end
        PS_ASYNC: begin
          if (i_handover) begin
            port_state <= PS_LISTEN;
          end
        end
        PS_SYNC: begin
          if (i_handover) begin
            port_state <= PS_LISTEN;
          end
        end
        default: begin
          port_state <= PS_LISTEN;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Baud detection.
  // --------------------------------------------------------------------
  // Sixteen bit times of pattern, shifted right by four, give the divisor.
  // Settling waits for 1.5 idle bit times before the receiver starts.
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ab_state <= AB_IDLE;
      span <= {`SLF_DIV_W{1'b0}};
      falls <= 4'h0;
      o_baud_div <= `SLF_MIN_DIV;
    end else if (i_handover || port_state == PS_SYNC) begin
      ab_state <= AB_IDLE;
    end else begin
      case (ab_state)
        AB_IDLE: begin
          if (port_state == PS_LISTEN && rx_fall) begin
            ab_state <= AB_MEAS;
            span <= {{(`SLF_DIV_W-1){1'b0}}, 1'b1}; // Fall cycle counts.
            falls <= 4'h0;
          end
        end
        AB_MEAS: begin
          span <= span + 1'b1;
          if (span == `SLF_MAX_SPAN) begin
            ab_state <= AB_IDLE;
          end else if (rx_fall) begin
            falls <= falls + 1'b1;
            if (falls == `SLF_SPAN_FALLS) begin
              if ((span >> `SLF_SPAN_SHIFT) >= `SLF_MIN_DIV) begin
                o_baud_div <= span >> `SLF_SPAN_SHIFT;
                ab_state <= AB_SETTLE;
                span <= {`SLF_DIV_W{1'b0}};
              end else begin
                ab_state <= AB_IDLE;
              end
            end
          end
        end
        AB_SETTLE: begin
          if (!rx) begin
            span <= {`SLF_DIV_W{1'b0}};
          end else if (ab_done) begin
            ab_state <= AB_RUN;
          end else begin
            span <= span + 1'b1;
          end
        end
        AB_RUN: begin
          ab_state <= AB_RUN;
        end
        default: begin
          ab_state <= AB_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Async receiver.
  // --------------------------------------------------------------------
  // Samples mid-bit; drops start glitches and characters with a low stop bit.
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rx_busy <= 1'b0;
      rx_cnt <= {`SLF_DIV_W{1'b0}};
      rx_bits <= 4'h0;
      rx_shift <= 8'h00;
      async_stb <= 1'b0;
      async_data <= 8'h00;
    end else begin
      async_stb <= 1'b0;
      if (!rx_busy) begin
        if (ab_state == AB_RUN && rx_fall) begin
          rx_busy <= 1'b1;
          rx_cnt <= {1'b0, o_baud_div[`SLF_DIV_W-1:1]};
          rx_bits <= 4'h0;
        end
      end else if (rx_cnt != {`SLF_DIV_W{1'b0}}) begin
        rx_cnt <= rx_cnt - 1'b1;
      end else begin
        rx_cnt <= o_baud_div - 1'b1;
        rx_bits <= rx_bits + 1'b1;
        if (rx_bits == 4'h0) begin
          rx_busy <= !rx;
        end else if (rx_bits == `SLF_STOP_INDEX) begin
          rx_busy <= 1'b0;
          async_stb <= rx;
          async_data <= rx_shift;
        end else begin
          rx_shift <= {rx, rx_shift[7:1]};
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Sync slave.
  // --------------------------------------------------------------------
  // Clock idles high: out on the fall, in on the rise; deselect drops a partial byte.
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      spi_bits <= 3'h0;
      spi_in <= 8'h00;
      spi_out <= 8'h00;
      sync_stb <= 1'b0;
      sync_data <= 8'h00;
      o_sync_miso <= 1'b1;
      o_sync_miso_oe <= 1'b0;
    end else begin
      sync_stb <= 1'b0;
      o_sync_miso_oe <= spi_on;
      if (!spi_on) begin
        spi_bits <= 3'h0;
      end else begin
        if (sclk_fall) begin
          if (spi_bits == 3'h0) begin
            o_sync_miso <= tx_byte[7];
            spi_out <= {tx_byte[6:0], 1'b0};
          end else begin
            o_sync_miso <= spi_out[7];
            spi_out <= {spi_out[6:0], 1'b0};
          end
        end
        if (sclk_rise) begin
          spi_in <= {spi_in[6:0], mosi};
          spi_bits <= spi_bits + 1'b1;
          if (spi_bits == 3'h7) begin
            sync_stb <= 1'b1;
            sync_data <= {spi_in[6:0], mosi};
          end
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Answer bytes, received stream and host answer capture.
  // --------------------------------------------------------------------
  // A new request wins over the clear caused by sending the byte.
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ack_pend <= 1'b0;
      nak_pend <= 1'b0;
      resp_armed <= 1'b0;
      o_rx_valid <= 1'b0;
      o_rx_data <= 8'h00;
      o_resp_valid <= 1'b0;
      o_resp_ack <= 1'b0;
      o_resp_nak <= 1'b0;
      o_pll_enable <= 1'b0;
    end else begin
      o_pll_enable <= 1'b0;
      ack_pend <= i_send_ack || ab_done || (ack_pend && !take);
      nak_pend <= i_send_nak || (nak_pend && !(take && !ack_pend));
      o_rx_valid <= byte_stb;
      if (byte_stb) begin
        o_rx_data <= byte_val;
      end
      o_resp_valid <= resp_armed && byte_stb && (byte_val != `SLF_IDLE_BYTE);
      if (resp_armed && byte_stb && byte_val != `SLF_IDLE_BYTE) begin
        o_resp_ack <= (byte_val == `SLF_ACK_BYTE);
        o_resp_nak <= (byte_val == `SLF_NAK_BYTE);
      end
      resp_armed <= i_resp_arm ||
                    (resp_armed && !(byte_stb && byte_val != `SLF_IDLE_BYTE));
    end
  end

  // --------------------------------------------------------------------
  // Transmit buffer and async transmitter.
  // --------------------------------------------------------------------
  slf_fifo #(
    .WIDTH(`SLF_FIFO_WIDTH),
    .DEPTH(`SLF_FIFO_DEPTH),
    .AW(`SLF_FIFO_AW)
  ) u_fifo (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_in_valid(i_tx_valid),
    .o_in_ready(o_tx_ready),
    .i_in_data(i_tx_data),
    .o_out_valid(fifo_valid),
    .i_out_ready(fifo_pop),
    .o_out_data(fifo_data)
  );

  slf_uart_tx u_tx (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_div(o_baud_div),
    .i_start(tx_go),
    .i_data(tx_byte),
    .o_busy(tx_busy),
    .o_line(o_async_tx)
  );
endmodule
`default_nettype wire

/* verif/slf_front_sva.sv */
// Port-level checks of the loader link front end.
// Assumes one clock domain; bound to slf_front at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
`include "slf_defines.vh"
module slf_front_sva (
  input wire logic i_clock, // System clock.
  input wire logic i_rst_b, // Reset, active low.
  input wire logic i_sync_sel_b, // Sync select pin.
  input wire logic i_handover, // Handover pulse.
  input wire logic o_async_tx, // Async transmit pin.
  input wire logic o_sync_miso_oe, // Data-out drive enable.
  input wire logic [7:0] o_rx_data, // Received byte.
  input wire logic o_rx_valid, // Byte strobe.
  input wire logic o_resp_valid, // Answer strobe.
  input wire logic o_resp_ack, // Answer was acknowledge.
  input wire logic o_resp_nak, // Answer was negative.
  input wire logic o_async_sel, // Async locked.
  input wire logic o_sync_sel, // Sync locked.
  input wire logic [`SLF_DIV_W-1:0] o_baud_div, // Detected divisor.
  input wire logic o_pll_enable // PLL enable.
);
  // ----------------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------------
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  // A start bit spans at least sixteen clocks, so eight low cycles follow a fall.
  sequence s_line_low;
    (!o_async_tx) [*8];
  endsequence
  // A port lock may only drop shortly after a handover pulse.
  sequence s_handover_recent;
    $past(i_handover) || $past(i_handover, 2);
  endsequence
  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  AST_PLL_OFF: assert property (o_pll_enable == 1'b0)
    else $error("pll enable raised");
  AST_ONE_PORT: assert property (!(o_async_sel && o_sync_sel))
    else $error("both ports locked");
  AST_LOCK_KEPT: assert property ($fell(o_async_sel) || $fell(o_sync_sel) |-> s_handover_recent)
    else $error("port lock lost without handover");
  AST_OE_LOCKOUT: assert property (o_async_sel && $past(o_async_sel) |-> !o_sync_miso_oe)
    else $error("sync data driven while async locked");
  AST_OE_SELECT: assert property (i_sync_sel_b [*4] |-> !o_sync_miso_oe)
    else $error("sync data driven while deselected");
  AST_DIV_FLOOR: assert property (o_async_sel |-> o_baud_div >= 20'h00010)
    else $error("divisor below sixteen");
  AST_TX_IDLE: assert property (!o_async_sel && !$past(o_async_sel) |-> o_async_tx)
    else $error("async line active while unlocked");
  AST_START_LEN: assert property ($fell(o_async_tx) |-> s_line_low)
    else $error("start bit too short");
  AST_RX_PULSE: assert property (o_rx_valid |=> !o_rx_valid)
    else $error("byte strobe longer than one cycle");
  AST_RESP_NONZERO: assert property (o_resp_valid |-> o_rx_valid && o_rx_data != 8'h00)
    else $error("answer taken from a zero byte");
  AST_RESP_CODE: assert property (o_resp_valid |-> o_resp_ack == (o_rx_data == 8'hCC) &&
    o_resp_nak == (o_rx_data == 8'h33))
    else $error("answer flags disagree with byte");
endmodule
bind slf_front slf_front_sva chk (.*);
`default_nettype wire

/* verif/slf_host_model.sv */
// Loader host model: async 8N1 link and mode-3 sync master.
// Assumes the bench resolves the data-out wire.
`timescale 1ns/1ps
`default_nettype none
module slf_host_model #(
  parameter int BIT_NS = 1600, // Async bit time, thirty-two system clocks.
  parameter int SCK_NS = 400 // Sync clock period.
) (
  output var logic o_async_rx, // Host transmit into the block.
  input wire logic i_async_tx, // Block transmit to the host.
  output var logic o_sync_clk, // Host-made sync clock.
  output var logic o_sync_sel_b, // Slave select, active low.
  output var logic o_sync_mosi, // Host data out.
  input wire logic i_sync_miso // Resolved block data line.
);
  // Lines idle high; the sync clock stands still between frames.
  initial begin
    o_async_rx = 1'b1;
    o_sync_clk = 1'b1;
    o_sync_sel_b = 1'b1;
    o_sync_mosi = 1'b1;
  end
  // One 8N1 character, LSB first.
  task automatic async_send(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      o_async_rx = f[i];
      #(BIT_NS);
    end
  endtask
  // Waits at most forty bit times for a start bit, then samples mid-bit.
  task automatic async_recv(output logic [7:0] d, output logic ok);
    int t;
    t = 0;
    d = 8'h00;
    while (i_async_tx !== 1'b0 && t < 40 * BIT_NS / 50) begin
      #50;
      t++;
    end
    ok = (t < 40 * BIT_NS / 50);
    #(BIT_NS * 3 / 2);
    for (int i = 0; i < 8; i++) begin
      d[i] = i_async_tx;
      #(BIT_NS);
    end
  endtask
  // Mode-3 byte, MSB first.
  task automatic spi_xfer(input logic [7:0] tx, output logic [7:0] rx);
    o_sync_sel_b = 1'b0;
    #(SCK_NS);
    for (int i = 7; i >= 0; i--) begin
      o_sync_clk = 1'b0;
      o_sync_mosi = tx[i];
      #(SCK_NS / 2);
      o_sync_clk = 1'b1;
      rx[i] = i_sync_miso;
      #(SCK_NS / 2);
    end
    #(SCK_NS);
    o_sync_sel_b = 1'b1;
    #(SCK_NS);
  endtask
endmodule
`default_nettype wire

/* verif/slf_front_test.sv */
// Self-checking bench of the loader link front end.
// Assumes the design files and the host model are compiled with it.
`timescale 1ns/1ps
`default_nettype none
module slf_front_test;
  logic i_clock = 1'b0, i_rst_b = 1'b0, i_tx_valid = 1'b0, i_send_ack = 1'b0;
  logic i_send_nak = 1'b0, i_resp_arm = 1'b0, i_handover = 1'b0, miso_last = 1'b0;
  logic [7:0] i_tx_data = 8'h00, rx_last = 8'h00, r;
  logic ok;
  int n_fail = 0, n_checks = 0, rx_cnt = 0, resp_cnt = 0, n, k;
  wire logic async_rx, async_tx, sync_clk, sync_sel_b, sync_mosi, miso, miso_oe, miso_w;
  wire logic rx_valid, tx_ready, resp_valid, resp_ack, resp_nak, async_sel, sync_sel, pll_en;
  wire logic [7:0] rx_data;
  wire logic [19:0] baud_div;
  // ----------------------------------------------------------------------
  // Clock, design, host and monitors
  // ----------------------------------------------------------------------
  always #25 i_clock = ~i_clock;
  // A released data-out line shows the inverse of its last value.
  assign miso_w = miso_oe ? miso : ~miso_last;
  slf_front uut (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_async_rx(async_rx),
    .o_async_tx(async_tx), .i_sync_clk(sync_clk), .i_sync_sel_b(sync_sel_b),
    .i_sync_mosi(sync_mosi), .o_sync_miso(miso), .o_sync_miso_oe(miso_oe),
    .o_rx_data(rx_data), .o_rx_valid(rx_valid), .i_tx_data(i_tx_data),
    .i_tx_valid(i_tx_valid), .o_tx_ready(tx_ready), .i_send_ack(i_send_ack),
    .i_send_nak(i_send_nak), .i_resp_arm(i_resp_arm), .o_resp_valid(resp_valid),
    .o_resp_ack(resp_ack), .o_resp_nak(resp_nak), .i_handover(i_handover),
    .o_async_sel(async_sel), .o_sync_sel(sync_sel), .o_baud_div(baud_div),
    .o_pll_enable(pll_en));
  slf_host_model host (.o_async_rx(async_rx), .i_async_tx(async_tx), .o_sync_clk(sync_clk),
    .o_sync_sel_b(sync_sel_b), .o_sync_mosi(sync_mosi), .i_sync_miso(miso_w));
  // Counts strobes; keeps the last byte and data-out level.
  always @(posedge i_clock) begin
    if (rx_valid === 1'b1) begin
      rx_last <= rx_data;
      rx_cnt <= rx_cnt + 1;
    end
    if (resp_valid === 1'b1) resp_cnt <= resp_cnt + 1;
    if (miso_oe === 1'b1) miso_last <= miso;
  end
  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check_bit(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic check_word(input string what, input logic [19:0] exp, input logic [19:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cycles(input int c);
    repeat (c) @(negedge i_clock);
  endtask
  task automatic pulse(ref logic s);
    @(negedge i_clock) s = 1'b1;
    @(negedge i_clock) s = 0;
  endtask
  task automatic do_reset();
    @(negedge i_clock) i_rst_b = 1'b0;
    cycles(20);
    i_rst_b = 1'b1;
    cycles(1);
  endtask
  // Bounded wait for a byte strobe past count c.
  task automatic wait_rx(input int c);
    k = 0;
    while (rx_cnt == c && k < 400) begin
      cycles(1);
      k++;
    end
    if (k == 400) begin
      n_fail++;
      $display("Error rx_valid expected pulse seen none");
      print_verdict();
    end
  endtask
  // One sync byte with a check of the byte read back.
  task automatic spi_chk(input logic [7:0] tx, input logic [7:0] exp);
    host.spi_xfer(tx, r);
    check_word("sync read byte", 20'(exp), 20'(r));
  endtask
  // Cuts a hang short.
  initial begin
    #5ms;
    n_fail++;
    $display("Error run time expected end seen overrun");
    print_verdict();
  end
  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    do_reset();
    check_word("baud_div reset", 20'h00010, baud_div);
    check_bit("pll_enable", 1'b0, pll_en);
    host.async_send(8'h55);
    host.async_send(8'h55);
    host.async_recv(r, ok);
    check_bit("ack arrived", 1'b1, ok);
    check_word("ack byte", 20'h000CC, 20'(r));
    check_bit("async_sel", 1'b1, async_sel);
    check_word("baud_div", 20'h00020, baud_div);
    n = rx_cnt;
    host.async_send(8'hA5);
    wait_rx(n);
    check_word("async rx byte", 20'h000A5, 20'(rx_last));
    host.spi_xfer(8'h3C, r);
    cycles(10);
    check_bit("sync_sel while async", 1'b0, sync_sel);
    check_word("rx count", 20'(n + 1), 20'(rx_cnt));
    pulse(i_handover);
    cycles(5);
    check_bit("async_sel after handover", 1'b0, async_sel);
    $display("async test done");
    do_reset();
    spi_chk(8'h3C, 8'h00);
    cycles(5);
    check_bit("sync_sel", 1'b1, sync_sel);
    check_word("sync rx byte", 20'h0003C, 20'(rx_last));
    host.async_send(8'h55);
    host.async_send(8'h55);
    cycles(100);
    check_bit("async_sel while sync", 1'b0, async_sel);
    k = 0;
    while (tx_ready === 1'b1 && k < 12) begin
      i_tx_data = 8'hF0 + 8'(k);
      i_tx_valid = 1'b1;
      cycles(1);
      k++;
    end
    i_tx_valid = 1'b0;
    check_word("buffer fill count", 20'h00008, 20'(k));
    pulse(i_send_ack);
    spi_chk(8'h00, 8'hCC);
    for (int i = 0; i < 8; i++) spi_chk(8'h00, 8'hF0 + 8'(i));
    check_bit("tx_ready after drain", 1'b1, tx_ready);
    pulse(i_send_nak);
    spi_chk(8'h00, 8'h33);
    spi_chk(8'h00, 8'h00);
    pulse(i_resp_arm);
    n = resp_cnt;
    host.spi_xfer(8'h00, r);
    cycles(5);
    check_word("answer count on zero", 20'(n), 20'(resp_cnt));
    host.spi_xfer(8'h33, r);
    cycles(5);
    check_word("answer count", 20'(n + 1), 20'(resp_cnt));
    check_bit("resp_nak", 1'b1, resp_nak);
    check_bit("resp_ack", 1'b0, resp_ack);
    $display("sync test done");
    print_verdict();
  end
endmodule
`default_nettype wire
